// *** inc/tbi_pkg.sv ***
// constants and carrier types for the ten-bit-interface serdes word logic
// ----------------------------------------------------------------------------
// Overview of operation
// - controller presents a 10-bit character; device captures it on reference clock rise
// - captured character is serialized with bit zero leaving first
// - reference clock is both capture clock and serial bit-rate reference; here it is only the capture clock, serial bits run one per i_clk cycle
// - loopback low sends serial data; high holds positive output high, negative low
// - loopback high feeds the own serial transmit stream into the receiver
// - receiver takes the external serial input only while loopback is low
// - received character updates on each rising edge of either recovered clock
// - received bit zero holds the earliest serial bit of the character
// - two complementary recovered clocks run at one twentieth of the bit rate
// - comma enable high detects and realigns; low keeps alignment, indicator off
// - comma indicator high half a recovered period for pattern 0011111XXX
// - comma indicator asserts only in cycles launched by the inverted recovered clock
// - serial input to character output latency within 15 to 34 bit periods
// - receiver acquires lock to idle pattern within 2.0 microseconds
// - recovered clocks keep running whether or not locked to serial data
// ----------------------------------------------------------------------------
package tbi_pkg;
  localparam int CHAR_W = 10;
  localparam logic [3:0] LAST_BIT = 4'h9;
  // comma pattern, bit zero first: 0 0 1 1 1 1 1 x x x
  localparam logic [9:0] COMMA_MASK = 10'h07f;
  localparam logic [9:0] COMMA_VAL = 10'h07c;
  localparam int SYNC_STAGES = 2;
  // serial delay pad so latency falls inside the 15..34 bit window
  localparam int RX_PAD = 12;
  localparam int LAT_MIN_BC = 15;
  localparam int LAT_MAX_BC = 34;
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCK_TIME_NS = 2000;
  localparam int LOCK_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int LOCK_W = $clog2(LOCK_CYC + 1);
  localparam logic [9:0] RESET_CHAR = 10'h000;

  // pin inputs sampled from outside the clock domain
  typedef struct packed {
    logic ref_clock_in;
    logic loopback_select;
    logic comma_detect_enable;
    logic rx_serial;
    logic [CHAR_W-1:0] tx_char_in;
  } tbi_pins_t;

  localparam int PINS_W = $bits(tbi_pins_t);
endpackage

// *** rtl/tbi_serdes_word.sv ***
// word side of the ten-bit-interface serdes: capture, serialize, deserialize, comma align
`timescale 1ns/1ns
`default_nettype none
module tbi_serdes_word (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ref_clock_in,
  input wire logic [tbi_pkg::CHAR_W-1:0] i_tx_char_in,
  input wire logic i_loopback_select,
  input wire logic i_comma_detect_enable,
  input wire logic i_rx_serial,
  output logic o_tx_p,
  output logic o_tx_n,
  output logic [tbi_pkg::CHAR_W-1:0] o_rx_char_out,
  output logic o_recovered_clock_a,
  output logic o_recovered_clock_b,
  output logic o_comma_found
);
  import tbi_pkg::*;

  typedef struct packed {
    logic ref_q;
    logic [CHAR_W-1:0] hold;
    logic [CHAR_W-1:0] sh;
    logic [3:0] tcnt;
    logic txp;
    logic txn;
    logic [RX_PAD-1:0] pad;
    logic [CHAR_W-1:0] win;
    logic [3:0] rcnt;
    logic [CHAR_W-1:0] rchar;
    logic rclk_a;
    logic rclk_b;
    logic comma;
    logic [LOCK_W-1:0] lock_cnt;
  } tbi_state_t;

  tbi_pins_t pins_raw;
  tbi_pins_t pins;
  logic [PINS_W-1:0] pins_sync;
  tbi_state_t s_q;
  tbi_state_t s_d;
  logic ref_rise;
  logic rx_bit;
  logic [CHAR_W-1:0] win_next;
  logic comma_hit;
  logic realign;
  logic boundary;

  // ----------------------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------------------
  // every pin except the reset, the reference clock included, crosses two flops
  always_comb begin
    pins_raw.ref_clock_in = i_ref_clock_in;
    pins_raw.loopback_select = i_loopback_select;
    pins_raw.comma_detect_enable = i_comma_detect_enable;
    pins_raw.rx_serial = i_rx_serial;
    pins_raw.tx_char_in = i_tx_char_in;
  end

  tbi_sync #(
    .W(PINS_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(pins_raw),
    .o_sync(pins_sync)
  );

  assign pins = tbi_pins_t'(pins_sync);

  // ----------------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ref_q = pins.ref_clock_in;
    ref_rise = pins.ref_clock_in & ~s_q.ref_q;
    // capture on rise
    // the character bus went through the same two flops as the clock, so it is stable here
    if (ref_rise) begin
      s_d.hold = pins.tx_char_in;
    end
    // shared reference
    // one bit per cycle and one reload per ten bits, free-running; the word rate
    // does not follow the reference at all, a limitation of having a single clock
    // bit zero first
    if (s_q.tcnt == LAST_BIT) begin
      s_d.tcnt = 4'h0;
      s_d.sh = s_q.hold;
    end else begin
      s_d.tcnt = s_q.tcnt + 4'h1;
      s_d.sh = {1'b0, s_q.sh[CHAR_W-1:1]};
    end
    s_d.txp = pins.loopback_select ? 1'b1 : s_q.sh[0];
    s_d.txn = pins.loopback_select ? 1'b0 : ~s_q.sh[0];
    rx_bit = pins.loopback_select ? s_q.sh[0] : pins.rx_serial;
    s_d.pad = {rx_bit, s_q.pad[RX_PAD-1:1]};
    // earliest bit ends in bit zero
    win_next = {s_q.pad[0], s_q.win[CHAR_W-1:1]};
    s_d.win = win_next;
    comma_hit = ((win_next & COMMA_MASK) == COMMA_VAL);
    // move the boundary onto a comma
    // alignment is reached on the first comma, well inside the lock time
    realign = pins.comma_detect_enable & comma_hit & (s_q.rcnt != LAST_BIT);
    boundary = (s_q.rcnt == LAST_BIT) | realign;
    s_d.rcnt = boundary ? 4'h0 : s_q.rcnt + 4'h1;
    // recovered clocks toggle every word, locked or not
    if (boundary) begin
      s_d.rchar = win_next;
      // complementary half-rate pair
      // the pair toggles on every word, comma or not, so no character change
      // goes without a rising edge and the clocks never stall on a comma run
      s_d.rclk_a = ~s_q.rclk_a;
      s_d.rclk_b = s_q.rclk_a;
      // flag inverted-clock words only
      // a comma landing in a clock_a word passes unflagged; the far end has
      // to keep its commas in step with the inverted clock
      s_d.comma = pins.comma_detect_enable & comma_hit & s_q.rclk_a;
    end
    // lock watchdog
    // counts cycles with detection on since the last comma sat on a word
    // boundary; it feeds only a check, the alignment itself needs no timer
    if (!pins.comma_detect_enable || (boundary && comma_hit)) begin
      s_d.lock_cnt = '0;
    end else if (s_q.lock_cnt != LOCK_W'(LOCK_CYC)) begin
      s_d.lock_cnt = s_q.lock_cnt + LOCK_W'(1);
    end
    // indicator off while detection is disabled
    if (!pins.comma_detect_enable) begin
      s_d.comma = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.hold <= RESET_CHAR;
      s_q.sh <= RESET_CHAR;
      s_q.rclk_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  always_comb begin
    o_tx_p = s_q.txp;
    o_tx_n = s_q.txn;
    o_rx_char_out = s_q.rchar;
    o_recovered_clock_a = s_q.rclk_a;
    o_recovered_clock_b = s_q.rclk_b;
    o_comma_found = s_q.comma;
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_capture_on_rise: assert property (
    (pins.ref_clock_in && !s_q.ref_q) |=> (s_q.hold == $past(pins.tx_char_in)))
    else $error("transmit character not captured on reference rise");

  chk_serial_order: assert property (
    (s_q.tcnt == LAST_BIT) |=> (s_q.sh == $past(s_q.hold)) ##1 (s_q.sh[8:0] == $past(s_q.sh[9:1])))
    else $error("serializer does not send bit zero first");

  chk_wrap_levels: assert property (
    pins.loopback_select |=> (o_tx_p && !o_tx_n))
    else $error("output pair not held high and low in loopback");

  chk_normal_data: assert property (
    !pins.loopback_select |=> (o_tx_p == $past(s_q.sh[0])) && (o_tx_n != o_tx_p))
    else $error("output pair does not carry serial data");

  chk_clock_pair: assert property (
    o_recovered_clock_a != o_recovered_clock_b)
    else $error("recovered clocks not complementary");

  chk_char_on_edge: assert property (
    $changed(o_rx_char_out) |-> ($rose(o_recovered_clock_a) || $rose(o_recovered_clock_b)))
    else $error("received character changed without a recovered clock rise");

  chk_clock_runs: assert property (
    $rose(o_recovered_clock_a) |-> ##[1:10] $rose(o_recovered_clock_b))
    else $error("recovered clocks stopped");

  chk_comma_phase: assert property (
    $rose(o_comma_found) |-> $rose(o_recovered_clock_b))
    else $error("comma indicator rose outside an inverted clock cycle");

  chk_comma_pattern: assert property (
    o_comma_found |-> ((o_rx_char_out & COMMA_MASK) == COMMA_VAL))
    else $error("comma indicator high without comma pattern");

  chk_comma_disabled: assert property (
    !pins.comma_detect_enable |=> !o_comma_found)
    else $error("comma indicator high while detection disabled");

  chk_lock_time: assert property (
    s_q.lock_cnt != LOCK_W'(LOCK_CYC))
    else $error("no comma on a word boundary within the lock time");

  chk_lock_clear: assert property (
    (boundary && comma_hit) |=> (s_q.lock_cnt == '0))
    else $error("lock watchdog not cleared by an aligned comma");

  chk_lock_count: assert property (
    (pins.comma_detect_enable && !(boundary && comma_hit) && (s_q.lock_cnt != LOCK_W'(LOCK_CYC)))
      |=> (s_q.lock_cnt == $past(s_q.lock_cnt) + LOCK_W'(1)))
    else $error("lock watchdog not counting");

  chk_ref_track: assert property (
    1'b1 |=> (s_q.ref_q == $past(pins.ref_clock_in)))
    else $error("reference edge detector lost a sample");

  chk_hold_stable: assert property (
    !(pins.ref_clock_in && !s_q.ref_q) |=> $stable(s_q.hold))
    else $error("input register changed without a reference rise");

  chk_tcnt_range: assert property (
    s_q.tcnt <= LAST_BIT)
    else $error("bit counter left its ten-bit range");

  chk_tcnt_step: assert property (
    (s_q.tcnt != LAST_BIT) |=> (s_q.tcnt == $past(s_q.tcnt) + 4'h1))
    else $error("bit counter skipped a bit");

  chk_wrap_source: assert property (
    pins.loopback_select |=> (s_q.pad[RX_PAD-1] == $past(s_q.sh[0])))
    else $error("receiver not fed from the transmit stream in loopback");

  chk_ext_source: assert property (
    !pins.loopback_select |=> (s_q.pad[RX_PAD-1] == $past(pins.rx_serial)))
    else $error("receiver not fed from the serial input in normal mode");

  chk_pad_shift: assert property (
    1'b1 |=> (s_q.pad[RX_PAD-2:0] == $past(s_q.pad[RX_PAD-1:1])))
    else $error("latency pad did not shift");

  chk_rcnt_range: assert property (
    s_q.rcnt <= LAST_BIT)
    else $error("word counter left its ten-bit range");

  chk_word_restart: assert property (
    boundary |=> (s_q.rcnt == 4'h0))
    else $error("word counter not restarted at a boundary");

  chk_rx_stable: assert property (
    !boundary |=> $stable(o_rx_char_out))
    else $error("received character changed inside a word");

  chk_boundary_load: assert property (
    boundary |=> (o_rx_char_out == $past(win_next)))
    else $error("received character is not the deserializer window");

  chk_clock_toggle: assert property (
    boundary |=> $changed(o_recovered_clock_a))
    else $error("recovered clock did not toggle at a word boundary");

  chk_clock_still: assert property (
    !boundary |=> $stable(o_recovered_clock_a))
    else $error("recovered clock toggled inside a word");

  chk_clock_b_follow: assert property (
    boundary |=> (o_recovered_clock_b == $past(s_q.rclk_a)))
    else $error("inverted recovered clock out of step");

  chk_align_kept: assert property (
    (!pins.comma_detect_enable && (s_q.rcnt != LAST_BIT)) |=> (s_q.rcnt == $past(s_q.rcnt) + 4'h1))
    else $error("word boundary moved while detection disabled");

  chk_comma_short: assert property (
    $rose(o_comma_found) |-> ##[1:10] !o_comma_found)
    else $error("comma indicator stood longer than one word");

  chk_comma_hold: assert property (
    (o_comma_found && !boundary && pins.comma_detect_enable) |=> o_comma_found)
    else $error("comma indicator dropped inside its word");

  chk_comma_launch: assert property (
    (boundary && pins.comma_detect_enable && comma_hit && s_q.rclk_a) |=> o_comma_found)
    else $error("comma on an inverted clock word not flagged");

  chk_comma_clear: assert property (
    (boundary && !(pins.comma_detect_enable && comma_hit && s_q.rclk_a)) |=> !o_comma_found)
    else $error("comma indicator set on a word that may not carry it");

  chk_realign_move: assert property (
    realign |=> ((s_q.rcnt == 4'h0) && ((o_rx_char_out & COMMA_MASK) == COMMA_VAL)))
    else $error("word boundary not moved onto the comma");
endmodule
`default_nettype wire

// *** rtl/tbi_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module tbi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } tbi_sync_st_t;

  tbi_sync_st_t s_q;
  tbi_sync_st_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = i_async;
    s_d.safe = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.safe;
endmodule
`default_nettype wire

// *** test/tbi_ctrl_model.sv ***
// controller model: reference clock and transmit characters
`timescale 1ns/1ns
`default_nettype none
module tbi_ctrl_model (
  input wire logic [tbi_pkg::CHAR_W-1:0] i_char,
  output logic o_ref_clock_in,
  output logic [tbi_pkg::CHAR_W-1:0] o_tx_char_in
);
  import tbi_pkg::*;
  // ----------------------------------------
  // reference clock and character source
  // ----------------------------------------
  initial begin
    o_ref_clock_in = 1'b0;
    o_tx_char_in = 10'h000;
  end
  // free reference clock
  // a reference runs free, so it does not stop between characters
  always #24 o_ref_clock_in = ~o_ref_clock_in;
  // stable coded char
  // change only on the falling edge so the char is steady around each rise
  always @(negedge o_ref_clock_in) begin
    o_tx_char_in <= i_char;
  end
endmodule
`default_nettype wire

// *** test/tbi_serdes_word_tb.sv ***
// self-checking bench for the serdes word logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 400) begin @(negedge clk); n++; end if (!(c)) begin failures++; $display("[ERR] %0t timeout", $time); summarize(); end end
module tbi_serdes_word_tb;
  import tbi_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic loop = 1'b0;
  logic cden = 1'b0;
  logic rx_ser = 1'b0;
  logic ser_on = 1'b0;
  logic ref_clk, tx_p, tx_n, rca, rcb, comma;
  logic [9:0] tx_char, rx_char;
  logic [9:0] char_sel = 10'h000;
  logic [19:0] pat = {10'h283, COMMA_VAL};
  int idx = 0;
  int n = 0;
  int failures = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  // ----------------------------------------
  // far side: serial source and controller
  // ----------------------------------------
  // an idle line toggles so a stale level never looks like data
  always @(negedge clk) begin
    if (ser_on) begin
      rx_ser <= pat[idx];
      idx <= (idx == 19) ? 0 : idx + 1;
    end else begin
      rx_ser <= ~rx_ser;
    end
  end
  tbi_ctrl_model tbi_ctrl_model_inst (.i_char(char_sel), .o_ref_clock_in(ref_clk), .o_tx_char_in(tx_char));
  tbi_serdes_word tbi_serdes_word_inst (.i_clk(clk), .i_resetn(resetn), .i_ref_clock_in(ref_clk),
    .i_tx_char_in(tx_char), .i_loopback_select(loop), .i_comma_detect_enable(cden), .i_rx_serial(rx_ser),
    .o_tx_p(tx_p), .o_tx_n(tx_n), .o_rx_char_out(rx_char), .o_recovered_clock_a(rca),
    .o_recovered_clock_b(rcb), .o_comma_found(comma));
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset, then clock period with no data to lock to
  task automatic t_clocks();
    int k;
    repeat (8) @(negedge clk);
    `CHK(rcb, 1'b1)
    resetn = 1'b1;
    `WAIT(rca === 1'b0)
    `WAIT(rca === 1'b1)
    k = 0;
    `WAIT(rca === 1'b0)
    k = k + n;
    `WAIT(rca === 1'b1)
    `CHK(k + n, 20)
    `CHK(rcb, ~rca)
  endtask
  task automatic t_wrap();
    char_sel = COMMA_VAL;
    loop = 1'b1;
    cden = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({tx_p, tx_n}, 2'b10)
    `WAIT(comma === 1'b1)
    `CHK(rx_char, COMMA_VAL)
    `CHK(rcb, 1'b1)
    repeat (9) @(negedge clk);
    `CHK(comma, 1'b1)
    @(negedge clk);
    `CHK(comma, 1'b0)
  endtask
  task automatic t_ext();
    logic [29:0] bits;
    logic ok;
    logic [9:0] w_a;
    char_sel = 10'h283;
    loop = 1'b0;
    ser_on = 1'b1;
    repeat (60) @(negedge clk);
    `CHK(tx_n, ~tx_p)
    `WAIT(rx_char === 10'h283)
    `CHK(rx_char, 10'h283)
    // each recovered rise brings the next word
    // the aligned stream alternates comma and data, so two rises differ by both
    `WAIT(rca === 1'b0)
    `WAIT(rca === 1'b1)
    w_a = rx_char;
    `WAIT(rcb === 1'b1)
    `CHK(w_a ^ rx_char, 10'h283 ^ COMMA_VAL)
    ok = 1'b0;
    for (int k = 0; k < 30; k++) begin
      @(negedge clk);
      bits[k] = tx_p;
    end
    for (int k = 0; k < 20; k++) begin
      if (bits[k+:10] === 10'h283) ok = 1'b1;
    end
    `CHK(ok, 1'b1)
  endtask
  // alignment held while disabled, regained when enabled
  task automatic t_hold();
    int hits;
    hits = 0;
    cden = 1'b0;
    repeat (4) @(negedge clk);
    // slip the stream by three bits; non-blocking so the source reads it cleanly
    pat <= {pat[2:0], pat[19:3]};
    for (int k = 0; k < 80; k++) begin
      @(negedge clk);
      if (comma !== 1'b0) hits++;
      if (k > 40 && rx_char === 10'h283) hits++;
    end
    `CHK(hits, 0)
    cden = 1'b1;
    `WAIT(rx_char === 10'h283)
    `CHK(rx_char, 10'h283)
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    t_clocks();
    t_wrap();
    t_ext();
    t_hold();
    summarize();
  end
endmodule
`default_nettype wire
